// *** rtl/timer_free_running_counter.sv ***
/*
  Free-running 16-bit up-counter of a general purpose timer with
  prescaler, external tick input, buffered byte reads and wrap flag.
  Assumes an Avalon-MM master on the CPU clock and a synchronous
  external tick pin; capture and compare logic attach via count_o.
*/
`timescale 1ns/10ps

module timer_free_running_counter #(
  parameter bit FIRST_INSTANCE = 1'b1,
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [3:0]  byteenable_i,
  input  wire logic [31:0] writedata_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        ext_tick_pin_i,
  input  wire logic        cpu_irq_mask_i,
  input  wire logic        halt_i,
  output logic             timer_irq_o,
  output logic      [15:0] count_o
);
  import timer_pkg::*;

  timer_state_t st;
  timer_state_t next_st;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic       accept;
  logic       wr;
  logic       rd;
  logic       lane0;
  logic [7:0] wbyte;

  assign accept = (read_i || write_i) && st.waitreq;
  assign wr     = accept && write_i;
  assign rd     = accept && read_i;
  assign lane0  = byteenable_i[0];
  assign wbyte  = writedata_i[7:0];

  logic acc_main_low;
  logic acc_shadow_low;
  logic rd_high;
  logic rd_status;

  assign acc_main_low   = accept && (address_i == OFS_COUNT_LOW);
  assign acc_shadow_low = accept && (address_i == OFS_SHADOW_LOW);
  assign rd_high        = rd && (address_i == OFS_COUNT_HIGH ||
                                 address_i == OFS_SHADOW_HIGH);
  assign rd_status      = rd && (address_i == OFS_STATUS);

  logic wr_low;
  assign wr_low = wr && lane0 && (address_i == OFS_COUNT_LOW ||
                                  address_i == OFS_SHADOW_LOW);
  logic rd_low;
  assign rd_low = rd && (address_i == OFS_COUNT_LOW ||
                         address_i == OFS_SHADOW_LOW);

  // ************************************************************
  // Tick generation
  // ************************************************************
  logic       ext_pin;
  logic [2:0] div_mask;
  logic       int_tick;
  logic       ext_tick;
  logic       tick;
  logic       wrap;

  // Unbonded pin idles high, so it can never produce an edge
  assign ext_pin = EXT_PIN_BONDED ? ext_tick_pin_i : 1'b1;

  always_comb begin
    unique case (st.tick_source_select)
      SRC_DIV2: div_mask = 3'h1;
      SRC_DIV4: div_mask = 3'h3;
      SRC_DIV8: div_mask = 3'h7;
      SRC_EXT:  div_mask = 3'h7;
    endcase
  end

  assign int_tick = (st.tick_source_select != SRC_EXT) &&
                    ((st.presc & div_mask) == div_mask);

  // Edge found on registered pin samples; the pin is assumed slow
  assign ext_tick = (st.tick_source_select == SRC_EXT) &&
                    (st.ext_tick_edge_select ?
                     (st.ext_q && !st.ext_prev) :
                     (!st.ext_q && st.ext_prev));

  // Wait mode has no input here: the counter simply keeps going
  assign tick = !halt_i && (int_tick || ext_tick);
  assign wrap = tick && (st.count == COUNT_MAX);

  // ************************************************************
  // Read data mux
  // ************************************************************
  logic [7:0] rbyte;

  always_comb begin
    rbyte = 8'h00;
    unique case (address_i)
      OFS_COUNT_HIGH, OFS_SHADOW_HIGH:
        rbyte = st.count[15:8];
      OFS_COUNT_LOW, OFS_SHADOW_LOW:
        rbyte = st.lo_locked ? st.lo_buf : st.count[7:0];
      OFS_STATUS: begin
        rbyte[BIT_WRAP_FLAG] = st.wrap_flag;
        // Capture two and compare two flags always read zero
        rbyte[BIT_CAPTURE_TWO] = 1'b0;
        rbyte[BIT_COMPARE_TWO] = 1'b0;
      end
      OFS_CONTROL_ONE:
        rbyte[BIT_WRAP_IRQ_EN] = st.wrap_irq_enable;
      OFS_CONTROL_TWO: begin
        rbyte[BIT_SRC_LSB+1 -: 2] = st.tick_source_select;
        rbyte[BIT_EXT_EDGE]       = st.ext_tick_edge_select;
      end
      OFS_CMP2_HIGH:
        rbyte = FIRST_INSTANCE ? 8'h00 : st.cmp2_hi;
      OFS_CMP2_LOW:
        rbyte = FIRST_INSTANCE ? 8'h00 : st.cmp2_lo;
      default:
        rbyte = 8'h00;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st          = st;
    next_st.ext_q    = ext_pin;
    next_st.ext_prev = st.ext_q;

    // Prescaler frozen in halt so resumption keeps its phase
    if (!halt_i) begin
      next_st.presc = 3'(st.presc + 3'h1);
    end

    if (wr_low) begin
      next_st.count = COUNT_RESET;
      next_st.presc = 3'h0;
    end else if (tick) begin
      next_st.count = 16'(st.count + 16'h0001);
    end

    // Bus handshake: one wait cycle, then a one-cycle answer
    next_st.waitreq = 1'b1;
    if (accept) begin
      next_st.waitreq = 1'b0;
      next_st.rdata   = {24'h000000, rbyte};
    end

    if (wr && lane0) begin
      unique case (address_i)
        OFS_CONTROL_ONE:
          next_st.wrap_irq_enable = wbyte[BIT_WRAP_IRQ_EN];
        OFS_CONTROL_TWO: begin
          next_st.tick_source_select   = wbyte[BIT_SRC_LSB+1 -: 2];
          next_st.ext_tick_edge_select = wbyte[BIT_EXT_EDGE];
        end
        OFS_CMP2_HIGH: next_st.cmp2_hi = wbyte;
        OFS_CMP2_LOW:  next_st.cmp2_lo = wbyte;
        default: ;
      endcase
    end

    // Byte buffer: high read captures, low read releases
    if (rd_high && !st.lo_locked) begin
      next_st.lo_buf    = st.count[7:0];
      next_st.lo_locked = 1'b1;
    end else if (rd_low) begin
      next_st.lo_locked = 1'b0;
    end

    // Two-step clear; the shadow low byte is deliberately ignored
    if (rd_status && st.wrap_flag) begin
      next_st.clr_armed = 1'b1;
    end
    if (acc_main_low && st.clr_armed) begin
      next_st.wrap_flag = 1'b0;
      next_st.clr_armed = 1'b0;
    end
    // A wrap in the clearing cycle wins over the clear
    if (wrap) begin
      next_st.wrap_flag = 1'b1;
    end

    next_st.irq = st.wrap_flag && st.wrap_irq_enable &&
                  !cpu_irq_mask_i;
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Each instance owns all of its state, so twins reset in step
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st                      <= '0;
      st.count                <= COUNT_RESET;
      st.ext_q                <= 1'b1;
      st.ext_prev             <= 1'b1;
      st.waitreq              <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign readdata_o    = st.rdata;
  assign waitrequest_o = st.waitreq;
  assign timer_irq_o   = st.irq;
  assign count_o       = st.count;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_status_read_set;
    rd_status && st.wrap_flag;
  endsequence

  sequence s_main_low_access;
    acc_main_low && !wrap;
  endsequence

  sequence s_low_read_live;
    rd_low && !st.lo_locked;
  endsequence

  sequence s_low_read_held;
    rd_low && st.lo_locked;
  endsequence

  AST_LOW_WRITE_RELOAD: assert property (
    wr_low |=> st.count == COUNT_RESET)
    else $error("low byte write did not reload count");

  AST_WRAP_SETS_FLAG: assert property (
    wrap && !wr_low |=> st.wrap_flag && st.count == 16'h0000)
    else $error("wrap did not set flag with zero count");

  AST_SHADOW_KEEPS_FLAG: assert property (
    acc_shadow_low && st.wrap_flag |=> st.wrap_flag)
    else $error("shadow low access disturbed wrap flag");

  AST_TWO_STEP_CLEAR: assert property (
    s_status_read_set ##[2:3] s_main_low_access
    |=> !st.wrap_flag)
    else $error("two-step clear failed");

  AST_NO_CLEAR_UNARMED: assert property (
    st.wrap_flag && !st.clr_armed |=> st.wrap_flag)
    else $error("wrap flag cleared without status read");

  AST_BUFFER_FROZEN: assert property (
    st.lo_locked && !(rd && address_i == OFS_COUNT_LOW) &&
    !(rd && address_i == OFS_SHADOW_LOW) |=> $stable(st.lo_buf))
    else $error("buffered low byte changed");

  AST_HALT_HOLDS: assert property (
    halt_i && !wr_low |=> $stable(st.count))
    else $error("counter moved in halt");

  AST_IRQ_PENDING: assert property (
    st.wrap_flag && st.wrap_irq_enable && !cpu_irq_mask_i
    |=> timer_irq_o)
    else $error("enabled wrap did not raise interrupt");

  AST_IRQ_MASKED: assert property (
    cpu_irq_mask_i |=> !timer_irq_o)
    else $error("interrupt raised while masked");

  AST_EXT_STEP: assert property (
    ext_tick && !halt_i && !wr_low
    |=> st.count == 16'($past(st.count) + 16'h0001))
    else $error("external edge did not advance count");

  AST_DIV2_RATE: assert property (
    (st.tick_source_select == SRC_DIV2 && !halt_i && !wr_low &&
     !wr)[*3] |-> st.count != $past(st.count, 2))
    else $error("divide by two did not advance count");

  AST_FLAGS_ZERO: assert property (
    rd_status |=> readdata_o[BIT_CAPTURE_TWO] == 1'b0 &&
                  readdata_o[BIT_COMPARE_TWO] == 1'b0)
    else $error("capture or compare two flag not zero");

  AST_ANSWER_ONE: assert property (
    accept |=> !waitrequest_o ##1 waitrequest_o)
    else $error("bus answer not a single cycle");

  AST_COUNT_HOLDS: assert property (
    !tick && !wr_low |=> $stable(st.count))
    else $error("count moved without a tick");

  AST_COUNT_STEP: assert property (
    tick && !wr_low
    |=> st.count == 16'($past(st.count) + 16'h0001))
    else $error("tick did not advance count by one");

  AST_HIGH_VIEW: assert property (
    rd_high
    |=> readdata_o[7:0] == $past(st.count[15:8]))
    else $error("high byte read not the live count");

  AST_BUFFER_CAPTURE: assert property (
    rd_high && !st.lo_locked
    |=> st.lo_locked && st.lo_buf == $past(st.count[7:0]))
    else $error("high byte read did not buffer the low byte");

  AST_LIVE_LOW: assert property (
    s_low_read_live |=> readdata_o[7:0] == $past(st.count[7:0]))
    else $error("lone low byte read not the live count");

  AST_BUFFERED_LOW: assert property (
    s_low_read_held |=> readdata_o[7:0] == $past(st.lo_buf))
    else $error("low byte read not the buffered byte");

  AST_LOW_READ_UNLOCKS: assert property (
    rd_low |=> !st.lo_locked)
    else $error("low byte read did not end the sequence");

  AST_FLAG_ONLY_ON_WRAP: assert property (
    !st.wrap_flag && !wrap |=> !st.wrap_flag)
    else $error("wrap flag set without a wrap");

  AST_DIV4_RATE: assert property (
    (st.tick_source_select == SRC_DIV4 && !halt_i && !wr_low)[*5]
    |-> st.count != $past(st.count, 4))
    else $error("divide by four did not advance count");

  AST_CMP2_ZERO: assert property (
    FIRST_INSTANCE && rd &&
    (address_i == OFS_CMP2_HIGH || address_i == OFS_CMP2_LOW)
    |=> readdata_o == 32'h00000000)
    else $error("compare two register readable");

  AST_IRQ_NEEDS_FLAG: assert property (
    !st.wrap_flag |=> !timer_irq_o)
    else $error("interrupt raised without wrap flag");

  AST_NO_ANSWER_UNASKED: assert property (
    !accept |=> waitrequest_o)
    else $error("bus answered without a request");

endmodule : timer_free_running_counter

// *** rtl/timer_pkg.sv ***
/*
  Constants, register map and state layout of the free-running timer
  counter. Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package timer_pkg;

  // ************************************************************
  // Register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [5:0] OFS_COUNT_HIGH  = 6'h00;
  localparam logic [5:0] OFS_COUNT_LOW   = 6'h04;
  localparam logic [5:0] OFS_SHADOW_HIGH = 6'h08;
  localparam logic [5:0] OFS_SHADOW_LOW  = 6'h0C;
  localparam logic [5:0] OFS_STATUS      = 6'h10;
  localparam logic [5:0] OFS_CONTROL_ONE = 6'h14;
  localparam logic [5:0] OFS_CONTROL_TWO = 6'h18;
  localparam logic [5:0] OFS_CMP2_HIGH   = 6'h1C;
  localparam logic [5:0] OFS_CMP2_LOW    = 6'h20;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_WRAP_FLAG     = 5;  // timer_status_reg
  localparam int BIT_CAPTURE_TWO   = 4;  // timer_status_reg
  localparam int BIT_COMPARE_TWO   = 3;  // timer_status_reg
  localparam int BIT_WRAP_IRQ_EN   = 5;  // timer_control_one
  localparam int BIT_SRC_LSB       = 2;  // timer_control_two [3:2]
  localparam int BIT_EXT_EDGE      = 0;  // timer_control_two

  // ************************************************************
  // Values
  // ************************************************************
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [1:0]  SRC_DIV2    = 2'h0;
  localparam logic [1:0]  SRC_DIV4    = 2'h1;
  localparam logic [1:0]  SRC_DIV8    = 2'h2;
  localparam logic [1:0]  SRC_EXT     = 2'h3;

  typedef struct packed {
    logic [2:0]  presc;
    logic [15:0] count;
    logic        wrap_flag;
    logic        clr_armed;
    logic [7:0]  lo_buf;
    logic        lo_locked;
    logic        ext_q;
    logic        ext_prev;
    logic        wrap_irq_enable;
    logic [1:0]  tick_source_select;
    logic        ext_tick_edge_select;
    logic [7:0]  cmp2_hi;
    logic [7:0]  cmp2_lo;
    logic        waitreq;
    logic [31:0] rdata;
    logic        irq;
  } timer_state_t;

endpackage : timer_pkg

// *** sim/timer_free_running_counter_test.sv ***
/*
  Self-checking bench of the free-running timer counter: bus access,
  wrap flag and interrupt, halt, tick sources and buffered byte reads.
  Assumes the register map of timer_pkg and an Avalon slave with
  waitrequest; a reference model checks the count on every rising clock edge.
*/
`timescale 1ns/10ps

module timer_free_running_counter_test;
  import timer_pkg::*;

  logic        clock_i        = 1'b0;
  logic        nrst_i         = 1'b0;
  logic [5:0]  address_i      = 6'h00;
  logic        read_i         = 1'b0;
  logic        write_i        = 1'b0;
  logic [31:0] writedata_i    = 32'h0;
  logic        ext_tick_pin_i = 1'b0;
  logic        cpu_irq_mask_i = 1'b1;
  logic        halt_i         = 1'b0;
  logic [31:0] readdata_o;
  logic        waitrequest_o;
  logic        timer_irq_o;
  logic [15:0] count_o;
  int          err_total      = 0;
  int          checked        = 0;
  int          cycles         = 0;
  logic [31:0] q;
  logic [15:0] s;
  logic [15:0] c;
  logic [15:0] first;
  int          n;
  int          exp_count;
  int          presc_cnt;
  int          src_sel;
  int          rising_sel;
  int          pin_hist[$];
  bit          bus_taken;
  bit          low_written;
  bit          tick_due;

  timer_free_running_counter uut (
    .clock_i        (clock_i),
    .nrst_i         (nrst_i),
    .address_i      (address_i),
    .read_i         (read_i),
    .write_i        (write_i),
    .byteenable_i   (4'h1),
    .writedata_i    (writedata_i),
    .readdata_o     (readdata_o),
    .waitrequest_o  (waitrequest_o),
    .ext_tick_pin_i (ext_tick_pin_i),
    .cpu_irq_mask_i (cpu_irq_mask_i),
    .halt_i         (halt_i),
    .timer_irq_o    (timer_irq_o),
    .count_o        (count_o)
  );

  always #20 clock_i = ~clock_i;

  // ************************************************************
  // Reference model: count, prescaler and tick source
  // ************************************************************
  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exp_count  = COUNT_RESET;
      presc_cnt  = 0;
      src_sel    = 0;
      rising_sel = 0;
      pin_hist   = '{1, 1};
    end else begin
      checked++;
      if (count_o !== 16'(exp_count)) begin
        err_total++;
        $display("ERROR count expected %h seen %h", 16'(exp_count), count_o);
      end
      bus_taken   = (read_i || write_i) && waitrequest_o === 1'b1;
      low_written = bus_taken && write_i &&
                    (address_i == OFS_COUNT_LOW ||
                     address_i == OFS_SHADOW_LOW);
      if (src_sel == 3) begin
        tick_due = rising_sel ? (pin_hist[1] && !pin_hist[0]) :
                                (!pin_hist[1] && pin_hist[0]);
      end else begin
        tick_due = presc_cnt % (2 << src_sel) == (2 << src_sel) - 1;
      end
      if (halt_i) begin
        tick_due = 1'b0;
      end else begin
        presc_cnt++;
      end
      if (low_written) begin
        exp_count = COUNT_RESET;
        presc_cnt = 0;
      end else if (tick_due) begin
        exp_count = (exp_count + 1) % 65536;
      end
      if (bus_taken && write_i && address_i == OFS_CONTROL_TWO) begin
        src_sel    = writedata_i[3:2];
        rising_sel = writedata_i[0];
      end
      pin_hist.push_back(ext_tick_pin_i);
      void'(pin_hist.pop_front());
    end
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // s: count at the taking edge, c: count while the answer stands
  task automatic bus(input bit wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_i);
    address_i   <= a;
    writedata_i <= {24'h0, d};
    read_i      <= ~wr;
    write_i     <= wr;
    @(posedge clock_i);
    s = count_o;
    // No wait count assumed; only the bench timeout ends a hang
    while (waitrequest_o !== 1'b0) begin
      @(posedge clock_i);
    end
    q = readdata_o;
    c = count_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    void'($urandom(20038));
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(negedge clock_i);
    chk("count after reset", 32'(COUNT_RESET), 32'(count_o));
    repeat (16) @(posedge clock_i);
    bus(0, OFS_STATUS, 8'h00);
    chk("status after wrap", 32'h20, q & 32'h38);
    bus(1, OFS_CONTROL_ONE, 8'h20);
    repeat (3) @(negedge clock_i);
    chk("irq masked", 32'h0, 32'(timer_irq_o));
    @(posedge clock_i);
    cpu_irq_mask_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk("irq pending issued", 32'h1, 32'(timer_irq_o));
    bus(0, OFS_SHADOW_LOW, 8'h00);
    bus(0, OFS_STATUS, 8'h00);
    chk("flag kept", 32'h20, q & 32'h20);
    bus(0, OFS_COUNT_LOW, 8'h00);
    bus(0, OFS_STATUS, 8'h00);
    chk("flag cleared", 32'h0, q & 32'h20);
    repeat (3) @(negedge clock_i);
    chk("irq dropped", 32'h0, 32'(timer_irq_o));
    @(posedge clock_i);
    halt_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    s = count_o;
    repeat (20) @(negedge clock_i);
    chk("count halted", 32'(s), 32'(count_o));
    @(posedge clock_i);
    halt_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    chk("count resumed", 32'(s + 16'h4), 32'(count_o));
    for (int m = 0; m < 3; m++) begin
      bus(1, OFS_CONTROL_TWO, 8'(m << 2));
      @(negedge clock_i);
      first = count_o;
      repeat (64) @(negedge clock_i);
      chk("ticks in 64", 32'(first + 16'(64 >> (m + 1))), 32'(count_o));
    end
    for (int e = 1; e >= 0; e--) begin
      bus(1, OFS_CONTROL_TWO, 8'h0C | 8'(e));
      n = 3 + $urandom % 5;
      @(negedge clock_i);
      first = count_o;
      repeat (n) begin
        @(posedge clock_i);
        ext_tick_pin_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        ext_tick_pin_i <= 1'b0;
        repeat (3) @(posedge clock_i);
      end
      repeat (6) @(negedge clock_i);
      chk("ext ticks", 32'(first + 16'(n)), 32'(count_o));
    end
    bus(1, OFS_CONTROL_TWO, 8'h00);
    for (int v = 0; v < 2; v++) begin
      repeat (5) @(posedge clock_i);
      bus(1, OFS_COUNT_LOW + 6'(8 * v), 8'($urandom));
      chk("low write reload", 32'(COUNT_RESET), 32'(c));
    end
    for (int v = 0; v < 2; v++) begin
      bus(0, OFS_COUNT_HIGH + 6'(8 * v), 8'h00);
      chk("high byte", {24'h0, s[15:8]}, q);
      first = s;
      repeat (5) @(posedge clock_i);
      bus(0, OFS_COUNT_HIGH + 6'(8 * v), 8'h00);
      bus(0, OFS_COUNT_LOW + 6'(8 * v), 8'h00);
      chk("buffered low", {24'h0, first[7:0]}, q);
      bus(0, OFS_COUNT_LOW + 6'(8 * v), 8'h00);
      chk("live low", {24'h0, s[7:0]}, q);
    end
    bus(1, OFS_CMP2_HIGH, 8'($urandom));
    bus(0, OFS_CMP2_HIGH, 8'h00);
    chk("compare two read", 32'h0, q);
    bus(0, 6'h3C, 8'h00);
    chk("unmapped read", 32'h0, q);
    final_report();
  end

endmodule : timer_free_running_counter_test
